// ---- verilog/mcbt_pkg.sv ----
`default_nettype none

package mcbt_pkg;

    // ****************************************************
    // Instruction stream widths
    // ****************************************************
    localparam int MCBT_OP_W = 5;
    localparam int MCBT_REG_W = 4;

    typedef logic [MCBT_OP_W-1:0] mcbt_op_t;

    // ****************************************************
    // Operation classes presented by the decoder
    // ****************************************************
    localparam mcbt_op_t OP_OTHER = 5'h00;
    localparam mcbt_op_t OP_ALIGNED_PACKED_DOUBLE_MOVE = 5'h01;
    localparam mcbt_op_t OP_ALIGNED_PACKED_SINGLE_MOVE = 5'h02;
    localparam mcbt_op_t OP_ALIGNED_PACKED_INTEGER_MOVE = 5'h03;
    localparam mcbt_op_t OP_UNALIGNED_PACKED_INTEGER_MOVE = 5'h04;
    localparam mcbt_op_t OP_UNALIGNED_PACKED_DOUBLE_MOVE = 5'h05;
    localparam mcbt_op_t OP_UNALIGNED_PACKED_SINGLE_MOVE = 5'h06;
    localparam mcbt_op_t OP_OTHER_VECTOR_MOVE = 5'h07;
    localparam mcbt_op_t OP_COMPUTE = 5'h08;
    localparam mcbt_op_t OP_SCALAR_LOAD = 5'h09;
    localparam mcbt_op_t OP_MEDIA_TO_VECTOR_TRANSFER = 5'h0a;
    localparam mcbt_op_t OP_PACKED_DOUBLE_TO_SINGLE_CONVERT = 5'h0b;
    localparam mcbt_op_t OP_PACKED_DOUBLE_TO_INT_CONVERT = 5'h0c;
    localparam mcbt_op_t OP_SCALAR_CONVERT = 5'h0d;
    localparam mcbt_op_t OP_LOW_HALF_MOVE = 5'h0e;
    localparam mcbt_op_t OP_HIGH_TO_LOW_MOVE = 5'h0f;
    localparam mcbt_op_t OP_SCALAR_SINGLE_MOVE = 5'h10;
    localparam mcbt_op_t OP_SCALAR_SQRT_DOUBLE = 5'h11;
    localparam mcbt_op_t OP_SCALAR_RECIP_SQRT_SINGLE = 5'h12;
    localparam mcbt_op_t OP_SCALAR_SQRT_SINGLE = 5'h13;
    localparam mcbt_op_t OP_MERGING_VECTOR_CONVERT = 5'h14;

    // ****************************************************
    // Cycle counts and reset values
    // ****************************************************
    localparam logic [1:0] INELIG_MOVE_DELAY = 2'h2;
    localparam logic [1:0] NO_EXTRA_DELAY = 2'h0;
    localparam logic MAP_VALID_RST = 1'b0;
    localparam logic [MCBT_REG_W-1:0] MAP_REG_RST = 4'h0;

endpackage : mcbt_pkg

`default_nettype wire

// ---- verilog/mcbt_cls_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface mcbt_cls_if;
    import mcbt_pkg::*;
    mcbt_op_t op;
    logic elig_move;
    logic other_move;
    logic compute;
    logic upper_clr;
    logic merge_cons;
    logic false_dep;

    modport dec
    (
        input op,
        output elig_move, other_move, compute,
        output upper_clr, merge_cons, false_dep
    );
    modport use_side
    (
        output op,
        input elig_move, other_move, compute,
        input upper_clr, merge_cons, false_dep
    );
endinterface : mcbt_cls_if

`default_nettype wire

// ---- verilog/mcbt_classify.sv ----
`timescale 1ns/1ps
`default_nettype none

module mcbt_classify
    import mcbt_pkg::*;
(
    mcbt_cls_if.dec cls
);

    // ****************************************************
    // Move classes
    // ****************************************************
    wire is_elig = (cls.op == OP_ALIGNED_PACKED_DOUBLE_MOVE)
        || (cls.op == OP_ALIGNED_PACKED_SINGLE_MOVE)
        || (cls.op == OP_ALIGNED_PACKED_INTEGER_MOVE)
        || (cls.op == OP_UNALIGNED_PACKED_INTEGER_MOVE)
        || (cls.op == OP_UNALIGNED_PACKED_DOUBLE_MOVE)
        || (cls.op == OP_UNALIGNED_PACKED_SINGLE_MOVE);
    wire is_other_move = (cls.op == OP_OTHER_VECTOR_MOVE)
        || (cls.op == OP_SCALAR_SINGLE_MOVE)
        || (cls.op == OP_LOW_HALF_MOVE)
        || (cls.op == OP_HIGH_TO_LOW_MOVE);

    // ****************************************************
    // Merge and compute classes
    // ****************************************************
    wire is_upper_clr = (cls.op == OP_SCALAR_LOAD)
        || (cls.op == OP_MEDIA_TO_VECTOR_TRANSFER)
        || (cls.op == OP_PACKED_DOUBLE_TO_SINGLE_CONVERT)
        || (cls.op == OP_PACKED_DOUBLE_TO_INT_CONVERT);
    wire is_merge_cons = (cls.op == OP_SCALAR_CONVERT)
        || (cls.op == OP_LOW_HALF_MOVE)
        || (cls.op == OP_HIGH_TO_LOW_MOVE)
        || (cls.op == OP_SCALAR_SINGLE_MOVE)
        || (cls.op == OP_SCALAR_SQRT_DOUBLE)
        || (cls.op == OP_SCALAR_RECIP_SQRT_SINGLE)
        || (cls.op == OP_SCALAR_SQRT_SINGLE);
    wire is_compute = (cls.op == OP_COMPUTE)
        || (cls.op == OP_SCALAR_CONVERT)
        || (cls.op == OP_SCALAR_SQRT_DOUBLE)
        || (cls.op == OP_SCALAR_RECIP_SQRT_SINGLE)
        || (cls.op == OP_SCALAR_SQRT_SINGLE)
        || (cls.op == OP_MERGING_VECTOR_CONVERT);

    assign cls.elig_move = is_elig;
    assign cls.other_move = is_other_move;
    assign cls.compute = is_compute;
    assign cls.upper_clr = is_upper_clr;
    assign cls.merge_cons = is_merge_cons;
    assign cls.false_dep = (cls.op == OP_MERGING_VECTOR_CONVERT);

endmodule : mcbt_classify

`default_nettype wire

// ---- verilog/mcbt_tracker.sv ----
// Function
// - Only the six aligned/unaligned packed register moves may be bypassed.
// - Compute after an ineligible move waits two extra cycles.
// - Only compute instructions bypass; dependent moves wait full latency.
// - One destination-to-source mapping held, applied to every dependent compute.
// - Writing mapped destination or source register invalidates the mapping.
// - A newer eligible move replaces the mapping; older dependents stall.
// - A pipeline redirect discards the mapping.
// - Unrelated instructions, ineligible moves included, leave mapping alone.
// - Compute reading mapped destination uses the move source instead.
// - New variant: upper-clearing producers add no merge dependency.
// - Legacy variant, selectable: lower-half consumers wait on merge.
// - Scalar loads, media transfer, packed double converts clear upper half.
// - Scalar converts, half moves, scalar single move, sqrt forms consume.
// - Some vector converts always depend on previous destination writer.
`timescale 1ns/1ps
`default_nettype none

module mcbt_tracker
    import mcbt_pkg::*;
#(
    parameter int NUM_REGS = 16
)
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic redirect_in,
    input wire logic legacy_merge_in,
    input wire logic instr_valid_in,
    input wire mcbt_op_t instr_op_in,
    input wire logic [MCBT_REG_W-1:0] instr_dst_in,
    input wire logic instr_writes_dst_in,
    input wire logic [MCBT_REG_W-1:0] instr_src_a_in,
    input wire logic instr_src_a_used_in,
    input wire logic [MCBT_REG_W-1:0] instr_src_b_in,
    input wire logic instr_src_b_used_in,
    output logic issue_valid_out,
    output mcbt_op_t issue_op_out,
    output logic [MCBT_REG_W-1:0] issue_dst_out,
    output logic [MCBT_REG_W-1:0] issue_src_a_out,
    output logic [MCBT_REG_W-1:0] issue_src_b_out,
    output logic issue_bypass_a_out,
    output logic issue_bypass_b_out,
    output logic [1:0] issue_extra_delay_out,
    output logic issue_wait_move_out,
    output logic issue_merge_dep_out,
    output logic map_valid_out,
    output logic [MCBT_REG_W-1:0] map_dst_out,
    output logic [MCBT_REG_W-1:0] map_src_out
);

    // ****************************************************
    // Helpers
    // ****************************************************
    function automatic logic map_hit(
        input logic valid,
        input logic used,
        input logic [MCBT_REG_W-1:0] mdst,
        input logic [MCBT_REG_W-1:0] src
    );
        map_hit = valid && used && (src == mdst);
    endfunction : map_hit

    function automatic logic [MCBT_REG_W-1:0] remap(
        input logic hit,
        input logic [MCBT_REG_W-1:0] msrc,
        input logic [MCBT_REG_W-1:0] src
    );
        remap = hit ? msrc : src;
    endfunction : remap

    // ****************************************************
    // Classification
    // ****************************************************
    mcbt_cls_if cls();

    mcbt_classify u_classify
    (
        .cls(cls)
    );

    assign cls.op = instr_op_in;

    // ****************************************************
    // State
    // ****************************************************
    logic map_valid;
    logic [MCBT_REG_W-1:0] map_dst;
    logic [MCBT_REG_W-1:0] map_src;
    // Per register: who wrote it last
    logic [NUM_REGS-1:0] wr_elig_move;
    logic [NUM_REGS-1:0] wr_inel_move;
    logic [NUM_REGS-1:0] wr_upper_clr;

    // A redirect flushes the instruction presented in the same cycle
    wire take = instr_valid_in && !redirect_in;
    wire writes = take && instr_writes_dst_in;
    wire new_map = take && cls.elig_move;
    // Indices are compared even when invalid; clearing nothing is harmless
    wire clobber = writes
        && ((instr_dst_in == map_dst) || (instr_dst_in == map_src));

    // ****************************************************
    // Mapping update
    // ****************************************************
    // A replacing move outranks a clobber of the old mapping
    wire next_map_valid = redirect_in ? 1'b0
        : new_map ? 1'b1
        : clobber ? 1'b0
        : map_valid;
    wire [MCBT_REG_W-1:0] next_map_dst = new_map ? instr_dst_in : map_dst;
    wire [MCBT_REG_W-1:0] next_map_src = new_map ? instr_src_a_in : map_src;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            map_valid <= MAP_VALID_RST;
        end
        else
        begin
            map_valid <= next_map_valid;
        end
    end

    // Indices keep a reset value too, so a stale compare never sees X
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            map_dst <= MAP_REG_RST;
            map_src <= MAP_REG_RST;
        end
        else
        begin
            map_dst <= next_map_dst;
            map_src <= next_map_src;
        end
    end

    // ****************************************************
    // Writer history
    // ****************************************************
    // One-hot of the written register; only written entries change
    wire [NUM_REGS-1:0] wr_mask = writes
        ? (NUM_REGS'(1) << instr_dst_in) : '0;
    wire [NUM_REGS-1:0] set_elig = cls.elig_move ? wr_mask : '0;
    wire [NUM_REGS-1:0] set_inel = cls.other_move ? wr_mask : '0;
    wire [NUM_REGS-1:0] set_upclr = cls.upper_clr ? wr_mask : '0;
    wire [NUM_REGS-1:0] next_wr_elig = (wr_elig_move & ~wr_mask) | set_elig;
    wire [NUM_REGS-1:0] next_wr_inel = (wr_inel_move & ~wr_mask) | set_inel;
    wire [NUM_REGS-1:0] next_wr_upclr =
        (wr_upper_clr & ~wr_mask) | set_upclr;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wr_elig_move <= '0;
        end
        else
        begin
            wr_elig_move <= next_wr_elig;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wr_inel_move <= '0;
        end
        else
        begin
            wr_inel_move <= next_wr_inel;
        end
    end

    // Redirects keep this history: the writers before them still retire
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wr_upper_clr <= '0;
        end
        else
        begin
            wr_upper_clr <= next_wr_upclr;
        end
    end

    // ****************************************************
    // Operand bypass
    // ****************************************************
    // Moves never bypass, they see the original register
    wire hit_a = cls.compute
        && map_hit(map_valid, instr_src_a_used_in, map_dst,
                   instr_src_a_in);
    wire hit_b = cls.compute
        && map_hit(map_valid, instr_src_b_used_in, map_dst,
                   instr_src_b_in);
    wire [MCBT_REG_W-1:0] eff_src_a =
        remap(hit_a, map_src, instr_src_a_in);
    wire [MCBT_REG_W-1:0] eff_src_b =
        remap(hit_b, map_src, instr_src_b_in);

    // ****************************************************
    // Delay and dependency decisions
    // ****************************************************
    // Unused operand fields may hold anything, so the use flags gate them
    wire a_inel = instr_src_a_used_in && wr_inel_move[instr_src_a_in];
    wire b_inel = instr_src_b_used_in && wr_inel_move[instr_src_b_in];
    wire a_elig = instr_src_a_used_in && wr_elig_move[instr_src_a_in];
    wire b_elig = instr_src_b_used_in && wr_elig_move[instr_src_b_in];

    // The history flag is not cleared by completion, so this is a
    // worst-case schedule hint; the scheduler ages it against wakeup
    wire inel_dep = cls.compute && (a_inel || b_inel);
    wire [1:0] extra_delay = inel_dep
        ? INELIG_MOVE_DELAY : NO_EXTRA_DELAY;

    // Unbypassed readers of an eligible move wait for its result
    wire wait_move = (a_elig && !hit_a) || (b_elig && !hit_b);

    // Merge: prior writer that cleared the upper half can be skipped
    // only in the newer variant
    wire dst_upclr = wr_upper_clr[instr_dst_in];
    wire merge_skip = dst_upclr && !legacy_merge_in;
    wire merge_dep = (cls.merge_cons && !merge_skip)
        || cls.false_dep;

    // ****************************************************
    // Issue outputs
    // ****************************************************
    // Flushed slots carry no bypass or hint to the scheduler
    wire next_bypass_a = take && hit_a;
    wire next_bypass_b = take && hit_b;
    wire [1:0] next_extra_delay = take ? extra_delay : NO_EXTRA_DELAY;
    wire next_wait_move = take && wait_move;
    wire next_merge_dep = take && merge_dep;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            issue_valid_out <= 1'b0;
            issue_op_out <= OP_OTHER;
            issue_dst_out <= MAP_REG_RST;
        end
        else
        begin
            issue_valid_out <= take;
            issue_op_out <= instr_op_in;
            issue_dst_out <= instr_dst_in;
        end
    end

    // Operand fields are only meaningful while issue valid is high
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            issue_src_a_out <= MAP_REG_RST;
            issue_src_b_out <= MAP_REG_RST;
            issue_bypass_a_out <= 1'b0;
            issue_bypass_b_out <= 1'b0;
        end
        else
        begin
            issue_src_a_out <= eff_src_a;
            issue_src_b_out <= eff_src_b;
            issue_bypass_a_out <= next_bypass_a;
            issue_bypass_b_out <= next_bypass_b;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            issue_extra_delay_out <= NO_EXTRA_DELAY;
            issue_wait_move_out <= 1'b0;
            issue_merge_dep_out <= 1'b0;
        end
        else
        begin
            issue_extra_delay_out <= next_extra_delay;
            issue_wait_move_out <= next_wait_move;
            issue_merge_dep_out <= next_merge_dep;
        end
    end

    // ****************************************************
    // Mapping visibility
    // ****************************************************
    assign map_valid_out = map_valid;
    assign map_dst_out = map_dst;
    assign map_src_out = map_src;

endmodule : mcbt_tracker

`default_nettype wire

// ---- bench/mcbt_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module mcbt_monitor
    import mcbt_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic redirect_in,
    input wire logic instr_valid_in,
    input wire mcbt_op_t instr_op_in,
    input wire logic [MCBT_REG_W-1:0] instr_dst_in,
    input wire logic instr_writes_dst_in,
    input wire logic [MCBT_REG_W-1:0] instr_src_a_in,
    input wire logic issue_valid_out,
    input wire mcbt_op_t issue_op_out,
    input wire logic [MCBT_REG_W-1:0] issue_src_a_out,
    input wire logic issue_bypass_a_out,
    input wire logic issue_merge_dep_out,
    input wire logic map_valid_out,
    input wire logic [MCBT_REG_W-1:0] map_dst_out,
    input wire logic [MCBT_REG_W-1:0] map_src_out
);
    // ********
    // Taken instruction and its class
    // ********
    wire take = instr_valid_in && !redirect_in;
    wire elig = instr_op_in inside {[5'h01:5'h06]};
    wire comp = issue_op_out inside {5'h08, 5'h0d, [5'h11:5'h14]};
    wire hit = instr_writes_dst_in && map_valid_out
        && (instr_dst_in == map_dst_out || instr_dst_in == map_src_out);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_reset_clears_map: assert property (disable iff (1'b0)
        rst_in |=> !map_valid_out) else $error("map valid after reset");
    a_issue_one_late: assert property (
        !$past(rst_in) |-> issue_valid_out == $past(take))
        else $error("issue valid not one cycle after take");
    a_elig_move_maps: assert property (
        take && elig |=> map_valid_out && map_dst_out == $past(instr_dst_in)
        && map_src_out == $past(instr_src_a_in)) else $error("no new map");
    a_bypass_uses_src: assert property (
        issue_bypass_a_out |-> $past(map_valid_out)
        && issue_src_a_out == $past(map_src_out)
        && $past(instr_src_a_in) == $past(map_dst_out))
        else $error("bypass without matching map");
    a_only_compute_bypass: assert property (
        issue_bypass_a_out |-> comp) else $error("non compute bypassed");
    a_write_kills_map: assert property (
        take && !elig && hit |=> !map_valid_out) else $error("map kept");
    a_unrelated_keeps: assert property (
        !redirect_in && !(instr_valid_in && (elig || hit)) |=>
        $stable(map_valid_out) && (!map_valid_out
        || ($stable(map_dst_out) && $stable(map_src_out))))
        else $error("map changed by unrelated instruction");
    a_redirect_drops: assert property (
        redirect_in |=> !map_valid_out && !issue_valid_out)
        else $error("redirect ignored");
    a_merge_convert: assert property (
        take && instr_op_in == OP_MERGING_VECTOR_CONVERT |=>
        issue_merge_dep_out) else $error("merging convert lost dependency");

    c_bypass: cover property (take && elig ##2 issue_bypass_a_out);
    c_redirect: cover property (redirect_in && map_valid_out);
    c_kill: cover property (take && !elig && hit);
endmodule : mcbt_monitor

bind mcbt_tracker mcbt_monitor mon
(
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .redirect_in(redirect_in),
    .instr_valid_in(instr_valid_in), .instr_op_in(instr_op_in),
    .instr_dst_in(instr_dst_in), .instr_writes_dst_in(instr_writes_dst_in),
    .instr_src_a_in(instr_src_a_in), .issue_valid_out(issue_valid_out),
    .issue_op_out(issue_op_out), .issue_src_a_out(issue_src_a_out),
    .issue_bypass_a_out(issue_bypass_a_out),
    .issue_merge_dep_out(issue_merge_dep_out),
    .map_valid_out(map_valid_out), .map_dst_out(map_dst_out),
    .map_src_out(map_src_out)
);

`default_nettype wire

// ---- bench/mcbt_dec_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module mcbt_dec_model
    import mcbt_pkg::*;
(
    output logic valid_out,
    output mcbt_op_t op_out,
    output logic [MCBT_REG_W-1:0] dst_out,
    output logic wr_out,
    output logic [MCBT_REG_W-1:0] src_a_out,
    output logic src_a_used_out,
    output logic [MCBT_REG_W-1:0] src_b_out,
    output logic src_b_used_out
);
    // ********
    // One decoded instruction a cycle, fields held as driven when idle
    // ********
    task automatic put(input logic v, input mcbt_op_t op,
        input logic [MCBT_REG_W-1:0] d, a, b, input logic w, au, bu);
        valid_out = v;
        op_out = op;
        dst_out = d;
        wr_out = w;
        src_a_out = a;
        src_a_used_out = au;
        src_b_out = b;
        src_b_used_out = bu;
    endtask : put
    initial put(1'b0, OP_OTHER, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0, 1'b0);
endmodule : mcbt_dec_model

`default_nettype wire

// ---- bench/move_compute_bypass_tracker_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module move_compute_bypass_tracker_test;
    import mcbt_pkg::*;
    typedef logic [MCBT_REG_W-1:0] mcbt_reg_t;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic redirect_in = 1'b0;
    logic legacy_merge_in = 1'b0;
    logic iv, iw, iau, ibu, ov, oba, obb, owm, omd, mv;
    mcbt_op_t iop, oop;
    mcbt_reg_t id, ia, ib, od, oa, ob, md, ms;
    logic [1:0] oxd;
    logic [7:0] pv, pop, pd, pa, pb, pba, pbb, pxd, pwm, pmd;
    logic pend = 1'b0;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int hist [16];
    int xv = 0;
    int xd = 0;
    int xs = 0;
    mcbt_op_t om [4] = '{5'h07, 5'h0e, 5'h0f, 5'h10};

    mcbt_tracker dut
    (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .redirect_in(redirect_in),
        .legacy_merge_in(legacy_merge_in), .instr_valid_in(iv),
        .instr_op_in(iop), .instr_dst_in(id), .instr_writes_dst_in(iw),
        .instr_src_a_in(ia), .instr_src_a_used_in(iau),
        .instr_src_b_in(ib), .instr_src_b_used_in(ibu),
        .issue_valid_out(ov), .issue_op_out(oop), .issue_dst_out(od),
        .issue_src_a_out(oa), .issue_src_b_out(ob),
        .issue_bypass_a_out(oba), .issue_bypass_b_out(obb),
        .issue_extra_delay_out(oxd), .issue_wait_move_out(owm),
        .issue_merge_dep_out(omd), .map_valid_out(mv),
        .map_dst_out(md), .map_src_out(ms)
    );
    mcbt_dec_model dec
    (
        .valid_out(iv), .op_out(iop), .dst_out(id), .wr_out(iw),
        .src_a_out(ia), .src_a_used_out(iau), .src_b_out(ib),
        .src_b_used_out(ibu)
    );

    // ********
    // Reference model: 1 eligible move, 2 other move, 3 upper clear
    // ********
    function automatic int kind(input mcbt_op_t op);
        if (op inside {[5'h01:5'h06]}) return 1;
        if (op inside {5'h07, [5'h0e:5'h10]}) return 2;
        return (op inside {[5'h09:5'h0c]}) ? 3 : 0;
    endfunction : kind

    function automatic logic comp(input mcbt_op_t op);
        return op inside {5'h08, 5'h0d, [5'h11:5'h14]};
    endfunction : comp

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("Checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // Outputs of the previous edge are compared before the next drive
    task automatic step(input logic v, rd, lg, input mcbt_op_t op,
        input mcbt_reg_t d, a, b, input logic w, au, bu);
        logic ba, bb;
        @(negedge clk_sys_in);
        if (pend && pv[0])
        begin
            chk(8'(oop), pop);
            chk(8'(od), pd);
            chk(8'(oa), pa);
            chk(8'(ob), pb);
            chk(8'(oba), pba);
            chk(8'(obb), pbb);
            chk(8'(oxd), pxd);
            chk(8'(owm), pwm);
            chk(8'(omd), pmd);
        end
        if (pend)
            chk(8'(ov), pv);
        chk(8'(mv), 8'(xv));
        if (xv != 0)
            chk({md, ms}, {4'(xd), 4'(xs)});
        pend = 1'b1;
        pv = 8'(v && !rd);
        ba = comp(op) && au && xv != 0 && a == xd;
        bb = comp(op) && bu && xv != 0 && b == xd;
        pop = 8'(op);
        pd = 8'(d);
        pa = ba ? 8'(xs) : 8'(a);
        pb = bb ? 8'(xs) : 8'(b);
        pba = 8'(ba);
        pbb = 8'(bb);
        pwm = 8'((au && !ba && hist[a] == 1) || (bu && !bb && hist[b] == 1));
        pxd = (comp(op) && ((au && hist[a] == 2) || (bu && hist[b] == 2)))
            ? 8'(INELIG_MOVE_DELAY) : 8'(NO_EXTRA_DELAY);
        pmd = 8'(op == OP_MERGING_VECTOR_CONVERT || (op inside
            {[5'h0d:5'h13]} && !(hist[d] == 3 && !lg)));
        if (pv[0] && kind(op) == 1)
        begin
            xv = 1;
            xd = d;
            xs = a;
        end
        else if (pv[0] && w && xv != 0 && (d == xd || d == xs))
            xv = 0;
        if (pv[0] && w)
            hist[d] = kind(op);
        if (rd)
            xv = 0;
        redirect_in = rd;
        legacy_merge_in = lg;
        dec.put(v, op, d, a, b, w, au, bu);
    endtask : step

    task automatic go(input mcbt_op_t op, input mcbt_reg_t d, a, b,
        input logic lg);
        step(1'b1, 1'b0, lg, op, d, a, b, 1'b1, 1'b1, kind(op) == 0);
    endtask : go

    task automatic rnd();
        mcbt_op_t op;
        op = 5'($urandom % 21);
        step($urandom % 8 != 0, $urandom % 16 == 0, $urandom % 2 == 1, op,
            4'($urandom % 4), 4'($urandom % 4), 4'($urandom % 4),
            kind(op) != 0 || $urandom % 2 == 1,
            kind(op) != 0 || $urandom % 2 == 1,
            kind(op) == 0 && $urandom % 2 == 1);
    endtask : rnd

    always #4 clk_sys_in = ~clk_sys_in;

    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles > 10000)
        begin
            errors++;
            test_done();
        end
    end

    initial
    begin
        void'($urandom(52592));
        repeat (20) @(negedge clk_sys_in);
        chk(8'(mv), 8'h00);
        chk(8'(ov), 8'h00);
        rst_in = 1'b0;
        for (int k = 1; k <= 6; k++)
        begin
            go(mcbt_op_t'(k), 4'h2, 4'h1, 4'h1, 1'b0);
            go(OP_COMPUTE, 4'h5, 4'h2, 4'h2, 1'b0);
        end
        foreach (om[k])
        begin
            go(om[k], 4'h4, 4'h3, 4'h3, 1'b0);
            go(OP_COMPUTE, 4'h6, 4'h4, 4'h1, 1'b0);
        end
        go(OP_ALIGNED_PACKED_DOUBLE_MOVE, 4'h2, 4'h1, 4'h1, 1'b0);
        go(OP_ALIGNED_PACKED_DOUBLE_MOVE, 4'h4, 4'h3, 4'h3, 1'b0);
        go(OP_COMPUTE, 4'h7, 4'h2, 4'h2, 1'b0);
        go(OP_COMPUTE, 4'h8, 4'h4, 4'h4, 1'b0);
        go(OP_ALIGNED_PACKED_SINGLE_MOVE, 4'h9, 4'h4, 4'h4, 1'b0);
        step(1'b1, 1'b1, 1'b0, OP_COMPUTE, 4'h7, 4'h9, 4'h9, 1, 1, 1);
        go(OP_COMPUTE, 4'h7, 4'h9, 4'h9, 1'b0);
        for (int c = 13; c <= 20; c++)
        begin
            go(mcbt_op_t'(9 + c % 4), 4'ha, 4'h0, 4'h0, c[0]);
            go(mcbt_op_t'(c), 4'ha, 4'hb, 4'hb, c[0]);
            go(mcbt_op_t'(9 + c % 4), 4'ha, 4'h0, 4'h0, c[1]);
            go(mcbt_op_t'(c), 4'ha, 4'hb, 4'hb, c[1]);
        end
        repeat (3000) rnd();
        step(1'b0, 1'b0, 1'b0, OP_OTHER, 4'h0, 4'h0, 4'h0, 0, 0, 0);
        step(1'b0, 1'b0, 1'b0, OP_OTHER, 4'hf, 4'hf, 4'hf, 1, 1, 1);
        test_done();
    end
endmodule : move_compute_bypass_tracker_test

`default_nettype wire
